// file: hdl/hp_pkg.sv
// shared constants for both ends of the host access port
package hp_pkg;
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 8;
  localparam int SADDR_W  = 14;
  localparam int HDR_BITS = 16;
  localparam int IDX_W    = 3;
  localparam int REG_N    = 8;
  localparam int TMR_W    = 4;
  localparam int CNT_W    = 8;
  // register indices, byte address equals index
  localparam logic [IDX_W-1:0] REG_CTRL   = 3'h0;
  localparam logic [IDX_W-1:0] REG_STATUS = 3'h1;
  localparam logic [IDX_W-1:0] REG_MASK   = 3'h2;
  localparam logic [IDX_W-1:0] REG_USER   = 3'h3;
  localparam logic [IDX_W-1:0] REG_USTAT  = 3'h4;
  localparam int               CTRL_IRQ_IDLE = 0;
  localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
  // serial functions of the shared data pins
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SWAP = 5;
  localparam int PIN_CPHA = 6;
  localparam int PIN_CPOL = 7;
  localparam logic [DATA_W-1:0] DEV_SPI_OE_N  = 8'hFE;
  localparam logic [DATA_W-1:0] HOST_SPI_OE_N = 8'h19;
  localparam logic RW_READ      = 1'b1;
  localparam logic MODE_STROBES = 1'b0;
  localparam logic MODE_DS      = 1'b1;
  // host pacing
  localparam int CLK_NS   = 10;
  localparam int PH_NS    = 40;
  localparam int HALF_NS  = 80;
  localparam int PH_CYC   = (PH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [TMR_W-1:0] PH_LOAD   = TMR_W'(PH_CYC - 1);
  localparam logic [TMR_W-1:0] STB_LOAD  = TMR_W'(2 * PH_CYC - 1);
  localparam logic [TMR_W-1:0] HALF_LOAD = TMR_W'(HALF_CYC - 1);
endpackage

// file: hdl/hp_link_if.sv
// pin-level link between the host processor and the device port
`timescale 1ns/10ps
interface hp_link_if;
  logic [hp_pkg::ADDR_W-1:0] addr;
  logic                      cs_n;
  logic                      read_or_data_strobe_n;
  logic                      wr_rw_n;
  logic                      ale;
  logic                      mode;
  logic                      spi_sel;
  logic [hp_pkg::DATA_W-1:0] dev_d;
  logic [hp_pkg::DATA_W-1:0] dev_oe_n;
  logic [hp_pkg::DATA_W-1:0] host_d;
  logic [hp_pkg::DATA_W-1:0] host_oe_n;
  logic [hp_pkg::DATA_W-1:0] data_bus;
  logic                      irq_d;
  logic                      irq_oe_n;
  logic                      irq_n;

  // pulled-up wires: an undriven bit reads high
  assign data_bus = (dev_d | dev_oe_n) & (host_d | host_oe_n);
  assign irq_n    = irq_d | irq_oe_n;

  modport dev (input addr, cs_n, read_or_data_strobe_n, wr_rw_n, ale, mode, spi_sel, data_bus,
               output dev_d, dev_oe_n, irq_d, irq_oe_n);
  modport host (output addr, cs_n, read_or_data_strobe_n, wr_rw_n, ale, mode, spi_sel, host_d, host_oe_n,
                input data_bus, irq_n);
endinterface // hp_link_if

// file: hdl/hp_device.sv
// device end of the host access port: parallel and serial register access
//
// Overview of operation
// (RULE1) parallel address is 11 bits, bit 0 lsb
// (RULE2) data bus released while deselected or reset
// (RULE3) strobes ignored unless chip select low
// (RULE4) strobe mode: drive data while read low
// (RULE5) strobe mode: write on write-strobe rising edge
// (RULE6) data strobe low for reads and writes
// (RULE7) direction high reads, low writes
// (RULE8) mode pin picks strobes or data strobe
// (RULE9) latch strobe high: live address used
// (RULE10) latch strobe fall: address captured, held
// (RULE11) non-multiplexed hosts hold latch strobe high
// (RULE12) select pin picks parallel or serial path
// (RULE13) serial: bit0 out, bit1 in, bit2 clock
// (RULE14) order 0: rw, a7-a13, a0-a6, burst, d0-d7
// (RULE15) order 1: rw, a13-a0, burst, d7-d0
// (RULE16) rw first, burst after address always
// (RULE17) phase select inverts shifting clock phase
// (RULE18) polarity select inverts the serial clock
// (RULE19) interrupt low while unmasked event pending
// (RULE20) idle interrupt level set by control bit
// (RULE21) burst bytes reach consecutive addresses
// (RULE22) host keeps serial options steady in frames
`timescale 1ns/10ps
module hp_device (
  input  wire logic                      clock_in,
  input  wire logic                      reset_n_in,
  hp_link_if.dev                         link,
  input  wire logic [hp_pkg::DATA_W-1:0] irq_event_in,
  input  wire logic [hp_pkg::DATA_W-1:0] user_status_in,
  output logic      [hp_pkg::DATA_W-1:0] user_ctrl_out
);
  import hp_pkg::*;

  localparam int SYNC_W = ADDR_W + DATA_W + 6;

  typedef enum logic [1:0] {SER_HDR, SER_DATA, SER_DONE} ser_phase_t;

  logic [SYNC_W-1:0]  sync1_q;
  logic [SYNC_W-1:0]  sync2_q;
  logic [ADDR_W-1:0]  addr_s;
  logic [DATA_W-1:0]  data_s;
  logic               cs_s;
  logic               rd_s;
  logic               wr_s;
  logic               ale_s;
  logic               mode_s;
  logic               spi_s;
  logic               rd_p_q;
  logic               wr_p_q;
  logic               ale_p_q;
  logic               eff_p_q;
  logic [ADDR_W-1:0]  addr_lat_q;
  logic [ADDR_W-1:0]  par_addr;
  logic [SADDR_W-1:0] par_addr_w;
  logic               par_rd;
  logic               par_wr;
  logic               eff_clk;
  logic               samp;
  logic               shft;
  ser_phase_t         ser_q;
  logic [3:0]         bit_q;
  logic [HDR_BITS-1:0] hdr_q;
  logic [SADDR_W-1:0] saddr_q;
  logic               rw_q;
  logic               burst_q;
  logic [DATA_W-1:0]  wbyte_q;
  logic [DATA_W-1:0]  wbyte_nx;
  logic [2:0]         dpos;
  logic               ser_wr;
  logic               wr_en;
  logic [SADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0]  wr_data;
  logic [DATA_W-1:0]  par_word;
  logic [DATA_W-1:0]  ser_word;
  logic [DATA_W-1:0]  regs_q [REG_N];
  logic [DATA_W-1:0]  dev_d_q;
  logic [DATA_W-1:0]  dev_oe_n_q;
  logic               irq_d_q;
  logic               irq_oe_n_q;
  logic               irq_act;

  function automatic logic [DATA_W-1:0] reg_rd(input logic [SADDR_W-1:0] a);
    reg_rd = (a[SADDR_W-1:IDX_W] == '0) ? regs_q[a[IDX_W-1:0]] : '0;
  endfunction

  // unpack the arrival-ordered header into an address
  function automatic logic [SADDR_W-1:0] dec_addr(input logic [HDR_BITS-1:0] seq, input logic swap);
    logic [SADDR_W-1:0] a;
    a = '0;
    for (int i = 0; i < SADDR_W; i++) begin
      if (swap) begin
        a[SADDR_W-1-i] = seq[1+i]; // RULE15
      end else if (i < 7) begin
        a[7+i] = seq[1+i]; // RULE14
      end else begin
        a[i-7] = seq[1+i]; // RULE14
      end
    end
    dec_addr = a;
  endfunction

  // every pin crosses two flops; idle values read as deselected
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= {link.addr, link.data_bus, link.cs_n, link.read_or_data_strobe_n,
                  link.wr_rw_n, link.ale, link.mode, link.spi_sel};
      sync2_q <= sync1_q;
    end
  end

  assign {addr_s, data_s, cs_s, rd_s, wr_s, ale_s, mode_s, spi_s} = sync2_q; // RULE1 RULE13

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_p_q  <= 1'b1;
      wr_p_q  <= 1'b1;
      ale_p_q <= 1'b1;
      eff_p_q <= 1'b0;
    end else begin
      rd_p_q  <= rd_s;
      wr_p_q  <= wr_s;
      ale_p_q <= ale_s;
      eff_p_q <= eff_clk;
    end
  end

  // ---------------- parallel path ----------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_lat_q <= '0;
    end else if (ale_p_q && !ale_s) begin
      addr_lat_q <= addr_s; // RULE10
    end
  end

  assign par_addr   = ale_s ? addr_s : addr_lat_q; // RULE9 RULE10
  assign par_addr_w = {{(SADDR_W-ADDR_W){1'b0}}, par_addr};

  // a strobe only counts with chip select low on the parallel path
  assign par_rd = !spi_s && !cs_s && !rd_s && (mode_s == MODE_STROBES || wr_s); // RULE3 RULE4 RULE7 RULE8 RULE12
  always_comb begin
    par_wr = 1'b0;
    if (!spi_s && !cs_s) begin // RULE3 RULE12
      if (mode_s == MODE_STROBES) begin // RULE8
        par_wr = wr_s && !wr_p_q; // RULE5
      end else begin
        par_wr = rd_s && !rd_p_q && !wr_s; // RULE6 RULE7
      end
    end
  end

  // ---------------- serial path ----------------
  assign eff_clk = data_s[PIN_SCLK] ^ data_s[PIN_CPOL]; // RULE18
  assign samp    = spi_s && !cs_s && (data_s[PIN_CPHA] ? (!eff_clk && eff_p_q) : (eff_clk && !eff_p_q)); // RULE17
  assign shft    = spi_s && !cs_s && (data_s[PIN_CPHA] ? (eff_clk && !eff_p_q) : (!eff_clk && eff_p_q)); // RULE17
  assign dpos    = data_s[PIN_SWAP] ? ~bit_q[2:0] : bit_q[2:0]; // RULE14 RULE15 RULE16

  always_comb begin
    wbyte_nx       = wbyte_q;
    wbyte_nx[dpos] = data_s[PIN_MOSI];
  end

  assign ser_wr = samp && ser_q == SER_DATA && bit_q[2:0] == 3'h7 && rw_q != RW_READ;

  // options are read live; the host keeps them still inside a frame
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ser_q   <= SER_HDR;
      bit_q   <= '0;
      hdr_q   <= '0;
      saddr_q <= '0;
      rw_q    <= RW_READ;
      burst_q <= 1'b0;
      wbyte_q <= '0;
    end else if (!spi_s || cs_s) begin
      ser_q <= SER_HDR;
      bit_q <= '0;
    end else if (samp) begin
      case (ser_q)
        SER_HDR: begin
          hdr_q[bit_q] <= data_s[PIN_MOSI];
          bit_q        <= bit_q + 4'h1;
          if (bit_q == 4'hF) begin
            ser_q   <= SER_DATA;
            saddr_q <= dec_addr(hdr_q, data_s[PIN_SWAP]);
            rw_q    <= hdr_q[0]; // RULE16
            burst_q <= data_s[PIN_MOSI]; // RULE16
          end
        end
        SER_DATA: begin
          wbyte_q <= wbyte_nx;
          bit_q   <= {1'b0, bit_q[2:0] + 3'h1};
          if (bit_q[2:0] == 3'h7) begin
            if (burst_q) begin
              saddr_q <= saddr_q + 14'h0001; // RULE21
            end else begin
              ser_q <= SER_DONE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------- register file ----------------
  assign wr_en    = par_wr || ser_wr;
  assign wr_addr  = spi_s ? saddr_q : par_addr_w;
  assign wr_data  = spi_s ? wbyte_nx : data_s; // RULE5
  assign par_word = reg_rd(par_addr_w);
  assign ser_word = reg_rd(saddr_q);

  for (genvar gi = 0; gi < REG_N; gi++) begin : g_reg
    localparam logic [IDX_W-1:0] IDX = IDX_W'(gi);
    logic hit;
    assign hit = wr_en && wr_addr[SADDR_W-1:IDX_W] == '0 && wr_addr[IDX_W-1:0] == IDX;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        regs_q[gi] <= REG_RST;
      end else if (IDX == REG_STATUS) begin
        // a new event beats a write-one clear of the same bit
        regs_q[gi] <= irq_event_in | (regs_q[gi] & ~(hit ? wr_data : '0));
      end else if (IDX == REG_USTAT) begin
        regs_q[gi] <= user_status_in;
      end else if (hit) begin
        regs_q[gi] <= wr_data;
      end
    end
  end

  assign user_ctrl_out = regs_q[REG_USER];

  // ---------------- pin drivers ----------------
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dev_d_q    <= '0;
      dev_oe_n_q <= '1; // RULE2
    end else if (cs_s) begin
      dev_oe_n_q <= '1; // RULE2
    end else if (spi_s) begin
      dev_oe_n_q <= DEV_SPI_OE_N; // RULE13
      if (shft && ser_q == SER_DATA && rw_q == RW_READ) begin
        dev_d_q[PIN_MISO] <= ser_word[dpos]; // RULE13
      end
    end else begin
      dev_oe_n_q <= par_rd ? '0 : '1; // RULE4
      dev_d_q    <= par_word; // RULE4
    end
  end

  assign irq_act = |(regs_q[REG_STATUS] & regs_q[REG_MASK]);

  // idle level 0 floats the pin for wired-or use, 1 drives it high
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_d_q    <= 1'b1;
      irq_oe_n_q <= 1'b1;
    end else if (irq_act) begin
      irq_d_q    <= 1'b0; // RULE19
      irq_oe_n_q <= 1'b0; // RULE19
    end else begin
      irq_d_q    <= 1'b1;
      irq_oe_n_q <= !regs_q[REG_CTRL][CTRL_IRQ_IDLE]; // RULE20
    end
  end

  assign link.dev_d    = dev_d_q;
  assign link.dev_oe_n = dev_oe_n_q;
  assign link.irq_d    = irq_d_q;
  assign link.irq_oe_n = irq_oe_n_q;
endmodule // hp_device

// file: hdl/hp_host.sv
// host end of the host access port: drives parallel or serial register cycles
`timescale 1ns/10ps
module hp_host (
  input  wire logic                       clock_in,
  input  wire logic                       reset_n_in,
  hp_link_if.host                         link,
  input  wire logic                       cfg_spi_sel_in,
  input  wire logic                       cfg_mode_in,
  input  wire logic                       cfg_mux_in,
  input  wire logic                       cfg_swap_in,
  input  wire logic                       cfg_cpha_in,
  input  wire logic                       cfg_cpol_in,
  input  wire logic                       req_valid_in,
  input  wire logic                       req_write_in,
  input  wire logic [hp_pkg::SADDR_W-1:0] req_addr_in,
  input  wire logic [3:0]                 req_len_in,
  input  wire logic [hp_pkg::DATA_W-1:0]  req_wdata_in,
  output logic                            req_ready_out,
  output logic                            byte_done_out,
  output logic      [hp_pkg::DATA_W-1:0]  rdata_out,
  output logic                            irq_pending_out
);
  import hp_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_STROBE, H_RECOV, H_SBIT, H_SEND, H_GAP} host_st_t;

  host_st_t          st_q;
  logic [TMR_W-1:0]  tmr_q;
  logic              half_q;
  logic [CNT_W-1:0]  bit_q;
  logic [CNT_W-1:0]  last_q;
  logic              write_q;
  logic              swap_q;
  logic              cpha_q;
  logic              cpol_q;
  logic [HDR_BITS-1:0] seq_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rbyte_q;
  logic [DATA_W-1:0] rbyte_nx;
  logic [DATA_W-1:0] wnext;
  logic [DATA_W-1:0] d_s1_q;
  logic [DATA_W-1:0] d_s2_q;
  logic              irq_s1_q;
  logic              irq_s2_q;
  logic [ADDR_W-1:0] pa_q;
  logic              cs_q;
  logic              rd_q;
  logic              wr_q;
  logic              ale_q;
  logic              mode_q;
  logic              spi_q;
  logic [DATA_W-1:0] hd_q;
  logic [DATA_W-1:0] hoe_q;
  logic [3:0]        len;
  logic              byte_end;

  function automatic logic [HDR_BITS-1:0] enc_hdr(input logic rd, input logic [SADDR_W-1:0] a,
                                                   input logic swap, input logic burst);
    logic [HDR_BITS-1:0] s;
    s     = '0;
    s[0]  = rd;
    s[15] = burst;
    for (int i = 0; i < SADDR_W; i++) begin
      s[1+i] = swap ? a[SADDR_W-1-i] : (i < 7 ? a[7+i] : a[i-7]);
    end
    enc_hdr = s;
  endfunction

  function automatic logic bit_val(input logic [CNT_W-1:0] b, input logic [HDR_BITS-1:0] s,
                                   input logic [DATA_W-1:0] w, input logic swap);
    bit_val = (b < CNT_W'(HDR_BITS)) ? s[b[3:0]] : w[swap ? ~b[2:0] : b[2:0]];
  endfunction

  assign len      = (req_len_in == 4'h0) ? 4'h1 : req_len_in;
  assign byte_end = bit_q >= CNT_W'(HDR_BITS) && bit_q[2:0] == 3'h7;
  assign wnext    = byte_end ? wdata_q + 8'h01 : wdata_q;
  always_comb begin
    rbyte_nx = rbyte_q;
    rbyte_nx[swap_q ? ~bit_q[2:0] : bit_q[2:0]] = d_s2_q[PIN_MISO];
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      d_s1_q   <= '1;
      d_s2_q   <= '1;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
    end else begin
      d_s1_q   <= link.data_bus;
      d_s2_q   <= d_s1_q;
      irq_s1_q <= link.irq_n;
      irq_s2_q <= irq_s1_q;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_pending_out <= 1'b0;
    end else begin
      irq_pending_out <= !irq_s2_q;
    end
  end

  // one sequencer paces every pin from flops
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= H_IDLE;
      tmr_q <= '0;
      half_q <= 1'b0;
      bit_q <= '0;
      last_q <= '0;
      write_q <= 1'b0;
      swap_q <= 1'b0;
      cpha_q <= 1'b0;
      cpol_q <= 1'b0;
      seq_q <= '0;
      wdata_q <= '0;
      rbyte_q <= '0;
      pa_q <= '0;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      ale_q <= 1'b1;
      mode_q <= MODE_STROBES;
      spi_q <= 1'b0;
      hd_q <= '0;
      hoe_q <= '1;
      req_ready_out <= 1'b1;
      byte_done_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      byte_done_out <= 1'b0;
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - 4'h1;
      end
      case (st_q)
        H_IDLE: begin
          spi_q  <= cfg_spi_sel_in;
          mode_q <= cfg_mode_in;
          swap_q <= cfg_swap_in;
          cpha_q <= cfg_cpha_in;
          cpol_q <= cfg_cpol_in;
          hoe_q  <= cfg_spi_sel_in ? HOST_SPI_OE_N : '1;
          hd_q   <= '0;
          hd_q[PIN_SWAP] <= cfg_swap_in;
          hd_q[PIN_CPHA] <= cfg_cpha_in;
          hd_q[PIN_CPOL] <= cfg_cpol_in;
          hd_q[PIN_SCLK] <= cfg_cpol_in;
          // options must equal the pins already shown, so accept only when settled
          if (req_valid_in && spi_q == cfg_spi_sel_in && swap_q == cfg_swap_in &&
              cpha_q == cfg_cpha_in && cpol_q == cfg_cpol_in && mode_q == cfg_mode_in) begin
            req_ready_out <= 1'b0;
            write_q <= req_write_in;
            wdata_q <= req_wdata_in;
            pa_q    <= req_addr_in[ADDR_W-1:0];
            seq_q   <= enc_hdr(!req_write_in, req_addr_in, cfg_swap_in, len > 4'h1);
            last_q  <= CNT_W'(HDR_BITS) + {1'b0, len, 3'h0} - 8'h01;
            bit_q   <= '0;
            tmr_q   <= PH_LOAD;
            if (spi_q) begin
              st_q <= H_SETUP;
            end else begin
              st_q <= cfg_mux_in ? H_ALE : H_SETUP; // RULE11
              cs_q <= cfg_mux_in;
              if (!cfg_mux_in && req_write_in) begin
                hoe_q <= '0;
                hd_q  <= req_wdata_in;
              end
              wr_q  <= (cfg_mode_in == MODE_DS) ? !req_write_in : 1'b1; // RULE7
            end
          end
        end
        H_ALE: if (tmr_q == '0) begin
          ale_q <= 1'b0;
          cs_q  <= 1'b0;
          tmr_q <= PH_LOAD;
          st_q  <= H_SETUP;
          if (write_q) begin
            hoe_q <= '0;
            hd_q  <= wdata_q;
          end
        end
        H_SETUP: if (tmr_q == '0) begin
          if (spi_q) begin
            cs_q           <= 1'b0;
            hd_q[PIN_MOSI] <= seq_q[0];
            half_q         <= 1'b0;
            tmr_q          <= HALF_LOAD;
            st_q           <= H_SBIT;
          end else begin
            if (mode_q == MODE_STROBES && write_q) begin
              wr_q <= 1'b0;
            end else begin
              rd_q <= 1'b0; // RULE6
            end
            if (!ale_q) begin
              pa_q <= '0;
            end
            tmr_q <= STB_LOAD;
            st_q  <= H_STROBE;
          end
        end
        H_STROBE: if (tmr_q == '0) begin
          rd_q  <= 1'b1;
          if (mode_q == MODE_STROBES) begin
            wr_q <= 1'b1;
          end
          if (!write_q) begin
            rdata_out     <= d_s2_q;
            byte_done_out <= 1'b1;
          end
          tmr_q <= PH_LOAD;
          st_q  <= H_RECOV;
        end
        H_RECOV: if (tmr_q == '0) begin
          cs_q  <= 1'b1;
          hoe_q <= '1;
          ale_q <= 1'b1;
          wr_q  <= 1'b1;
          tmr_q <= PH_LOAD;
          st_q  <= H_GAP;
        end
        H_SBIT: if (tmr_q == '0) begin
          tmr_q <= HALF_LOAD;
          if (!half_q) begin
            half_q         <= 1'b1;
            hd_q[PIN_SCLK] <= !cpol_q;
            if (cpha_q) begin
              hd_q[PIN_MOSI] <= bit_val(bit_q, seq_q, wdata_q, swap_q);
            end
          end else begin
            half_q         <= 1'b0;
            hd_q[PIN_SCLK] <= cpol_q;
            if (bit_q >= CNT_W'(HDR_BITS) && !write_q) begin
              rbyte_q <= rbyte_nx;
              if (byte_end) begin
                rdata_out     <= rbyte_nx;
                byte_done_out <= 1'b1;
              end
            end else if (byte_end) begin
              byte_done_out <= 1'b1;
            end
            wdata_q <= wnext;
            if (bit_q == last_q) begin
              st_q <= H_SEND;
            end else begin
              bit_q <= bit_q + 8'h01;
              if (!cpha_q) begin
                hd_q[PIN_MOSI] <= bit_val(bit_q + 8'h01, seq_q, wnext, swap_q);
              end
            end
          end
        end
        H_SEND: if (tmr_q == '0) begin
          cs_q  <= 1'b1;
          tmr_q <= PH_LOAD;
          st_q  <= H_GAP;
        end
        H_GAP: if (tmr_q == '0) begin
          req_ready_out <= 1'b1;
          st_q          <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.addr                  = pa_q;
  assign link.cs_n                  = cs_q;
  assign link.read_or_data_strobe_n = rd_q;
  assign link.wr_rw_n               = wr_q;
  assign link.ale                   = ale_q;
  assign link.mode                  = mode_q;
  assign link.spi_sel               = spi_q;
  assign link.host_d                = hd_q;
  assign link.host_oe_n             = hoe_q;
endmodule // hp_host

// file: testbench/hp_link_props.sv
// pin-level checks on the link between host and device ends
`timescale 1ns/10ps
module hp_link_props
  import hp_pkg::*;
(
  input logic              clock_in,
  input logic              reset_n_in,
  input logic              cs_n,
  input logic              read_or_data_strobe_n,
  input logic              wr_rw_n,
  input logic              mode,
  input logic              spi_sel,
  input logic [DATA_W-1:0] data_bus,
  input logic [DATA_W-1:0] dev_oe_n,
  input logic [DATA_W-1:0] host_oe_n
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // four samples leave room for the device's three-flop pin latency
  // looked at one edge on: the pin flops hold no value before the first clock edge of reset
  AST_RST_FREE: assert property (disable iff (1'b0) !reset_n_in |=> dev_oe_n == 8'hFF)
    else $error("bus driven during reset");
  AST_DESEL: assert property (cs_n [*4] |-> dev_oe_n == 8'hFF)
    else $error("bus driven while deselected");
  AST_RD0: assert property ((!spi_sel && !mode && !cs_n && !read_or_data_strobe_n) [*4] |-> dev_oe_n == 8'h00)
    else $error("strobe read not driven");
  AST_RD1: assert property ((!spi_sel && mode && wr_rw_n && !cs_n && !read_or_data_strobe_n) [*4]
    |-> dev_oe_n == 8'h00)
    else $error("data strobe read not driven");
  AST_REL: assert property ((!spi_sel && (mode ? !wr_rw_n : read_or_data_strobe_n)) [*4]
    |-> dev_oe_n == 8'hFF)
    else $error("bus driven outside read");
  AST_SPI_DEV: assert property ((spi_sel && !cs_n) [*4] |-> dev_oe_n == DEV_SPI_OE_N)
    else $error("device serial pins wrong");
  AST_SPI_HOST: assert property (spi_sel && !cs_n |-> host_oe_n == HOST_SPI_OE_N)
    else $error("host serial pins wrong");
  AST_SPI_CFG: assert property (spi_sel && !cs_n && !$past(cs_n) |-> $stable(data_bus[7:5]))
    else $error("serial options moved in frame");
  AST_DS_CS: assert property (!spi_sel && !read_or_data_strobe_n |-> !cs_n)
    else $error("strobe without select");
  cover property (spi_sel && $fell(cs_n));
  cover property (!spi_sel && mode && $rose(read_or_data_strobe_n));
  cover property (!spi_sel && !mode && $rose(wr_rw_n));
endmodule // hp_link_props

// file: testbench/host_cpu_port_parallel_serial_tb.sv
// bench joining host and device ends of the host access port
`timescale 1ns/10ps
module host_cpu_port_parallel_serial_tb;
  import hp_pkg::*;
  logic               clock_in = 0;
  logic               reset_n_in = 0;
  logic               sp = 0, md = 0, mx = 0, sw = 0, ph = 0, po = 0, vld = 0, wr = 0;
  logic [SADDR_W-1:0] ad = '0;
  logic [3:0]         ln = 4'h1;
  logic [7:0]         wd = 8'h00, ev = 8'h00, us = 8'h00, r, ud, rdata, ctrl;
  logic               rdy, done, irqp;
  logic [8:0]         q[$];
  logic [8:0]         e;
  int                 errors = 0, checks = 0, k;
  hp_link_if hp_link_if_i ();
  hp_device hp_device_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .link(hp_link_if_i.dev),
    .irq_event_in(ev), .user_status_in(us), .user_ctrl_out(ctrl));
  hp_host hp_host_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .link(hp_link_if_i.host),
    .cfg_spi_sel_in(sp), .cfg_mode_in(md), .cfg_mux_in(mx), .cfg_swap_in(sw), .cfg_cpha_in(ph),
    .cfg_cpol_in(po), .req_valid_in(vld), .req_write_in(wr), .req_addr_in(ad), .req_len_in(ln),
    .req_wdata_in(wd), .req_ready_out(rdy), .byte_done_out(done), .rdata_out(rdata),
    .irq_pending_out(irqp));
  hp_link_props hp_link_props_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .cs_n(hp_link_if_i.cs_n),
    .read_or_data_strobe_n(hp_link_if_i.read_or_data_strobe_n), .wr_rw_n(hp_link_if_i.wr_rw_n),
    .mode(hp_link_if_i.mode), .spi_sel(hp_link_if_i.spi_sel), .data_bus(hp_link_if_i.data_bus),
    .dev_oe_n(hp_link_if_i.dev_oe_n), .host_oe_n(hp_link_if_i.host_oe_n));
  always #5 clock_in = ~clock_in;
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wt(input logic v);
    int i;
    for (i = 0; i < 9000 && rdy !== v; i++) @(negedge clock_in);
    if (rdy !== v) begin
      errors++;
      results();
    end
  endtask
  // cf = {serial, data strobe, mux, cpol, cpha, swap}; for reads d is the expected first byte
  task automatic xf(input logic [5:0] cf, input int w, input logic [13:0] a, input int n,
    input logic [7:0] d);
    int i;
    @(negedge clock_in);
    {sp, md, mx, po, ph, sw} = cf;
    {wr, ad, ln, wd, vld} = {w[0], a, n[3:0], d, 1'b1};
    // parallel writes raise no byte pulse, so only serial writes leave skip notes
    if (w == 0 || cf[5]) begin
      for (i = 0; i < n; i++) q.push_back(w ? 9'h100 : {1'b0, d + 8'(i)});
    end
    wt(1'b0);
    vld = 0;
    wt(1'b1);
  endtask
  // serial write bytes leave a skip note so every pulse pops exactly one entry
  always @(negedge clock_in) begin
    if (done === 1'b1) begin
      if (q.size() == 0) chk(8'hFF, 8'h00);
      else begin
        e = q.pop_front();
        if (!e[8]) chk(rdata, e[7:0]);
      end
    end
  end
  initial begin
    void'($urandom(5678));
    us = 8'($urandom);
    r = 8'($urandom) | 8'h01;
    repeat (20) @(negedge clock_in);
    reset_n_in = 1;
    chk(ctrl, 8'h00);
    chk({7'h0, hp_link_if_i.irq_oe_n}, 8'h01);
    xf(6'h00, 1, 14'h0003, 1, r);
    chk(ctrl, r);
    xf(6'h00, 0, 14'h0003, 1, r);
    xf(6'h00, 0, 14'h0403, 1, 8'h00);
    xf(6'h10, 1, 14'h0002, 1, ~r);
    xf(6'h10, 0, 14'h0002, 1, ~r);
    xf(6'h08, 0, 14'h0003, 1, r);
    xf(6'h18, 1, 14'h0006, 1, 8'h5A);
    xf(6'h18, 0, 14'h0006, 1, 8'h5A);
    xf(6'h00, 1, 14'h0004, 1, ~us);
    xf(6'h00, 0, 14'h0004, 1, us);
    for (k = 0; k < 8; k++) begin
      ud = 8'($urandom);
      xf({3'h4, k[2:0]}, 1, 14'h0005, 4'h3, ud);
      xf({3'h4, k[2:0]}, 0, 14'h0005, 4'h3, ud);
    end
    xf(6'h21, 0, 14'h0003, 1, r);
    xf(6'h00, 1, 14'h0002, 1, 8'h01);
    @(negedge clock_in) ev = 8'h03;
    @(negedge clock_in) ev = 8'h00;
    for (k = 0; k < 50 && irqp !== 1'b1; k++) @(negedge clock_in);
    chk({7'h0, irqp}, 8'h01);
    chk({7'h0, hp_link_if_i.irq_n}, 8'h00);
    xf(6'h00, 1, 14'h0001, 1, 8'h01);
    chk({7'h0, irqp}, 8'h00);
    xf(6'h00, 1, 14'h0000, 1, 8'h01);
    chk({6'h0, hp_link_if_i.irq_oe_n, hp_link_if_i.irq_d}, 8'h01);
    chk(8'(q.size()), 8'h00);
    results();
  end
endmodule // host_cpu_port_parallel_serial_tb
